// >>> inc/spi_port_pkg.sv
package spi_port_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 16;
  localparam int FRAME_BITS = ADDR_W + DATA_W;
  localparam int CMD_W      = FRAME_BITS + 1;
  localparam int MEM_WORDS  = 256;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] ADDR_LAST = 5'(ADDR_W - 1);
  localparam logic [4:0] BIT_LAST  = 5'(FRAME_BITS - 1);
  localparam logic [4:0] BIT_DONE  = 5'(FRAME_BITS);
  // read-only measurement counter word
  localparam logic [7:0]  CYCLE_COUNT_ADDR  = 8'h20;
  localparam logic [15:0] CYCLE_COUNT_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 20;
  localparam int SCLK_MIN_PERIOD_NS = 1000;
  localparam int HALF_CYCLES =
    (SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] HALF_LAST = 5'(HALF_CYCLES - 1);
endpackage

// >>> inc/spi_port_if.sv
`timescale 1ns/1ps
interface spi_port_if;
  logic monitor_test_enable;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport device (
    input  monitor_test_enable,
    input  sel_n,
    input  sclk,
    input  mosi,
    output miso
  );
  modport host (
    output monitor_test_enable,
    output sel_n,
    output sclk,
    output mosi,
    input  miso
  );
endinterface

// >>> src/cmd_fifo.sv
`timescale 1ns/1ps
module cmd_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,       // system clock
  input  wire logic             rst_i,       // sync reset, high
  input  wire logic             in_valid_i,  // write request
  output logic                  in_ready_o,  // not full
  input  wire logic [WIDTH-1:0] in_data_i,   // write word
  output logic                  out_valid_o, // not empty
  input  wire logic             out_ready_i, // pop request
  output logic [WIDTH-1:0]      out_data_o   // head word
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr_reg;
  logic [PW:0]      wr_ptr_next;
  logic [PW:0]      rd_ptr_reg;
  logic [PW:0]      rd_ptr_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // pointers, one extra bit tells full from empty
  // ----------------------------------------------------------------
  always_comb begin
    empty       = (wr_ptr_reg == rd_ptr_reg);
    full        = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                  (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
    push        = in_valid_i && !full;
    pop         = out_ready_i && !empty;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // storage has no reset; empty flag guards stale words
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[PW-1:0]] <= in_data_i;
    end
  end

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr_reg[PW-1:0]];
endmodule

// >>> src/spi_port_host.sv
`timescale 1ns/1ps
module spi_port_host (
  input  wire logic        clk_i,         // system clock, 50 MHz
  input  wire logic        rst_i,         // sync reset, high
  spi_port_if.host         link,          // serial pins
  input  wire logic        port_enable_i, // request port enable
  input  wire logic        cmd_valid_i,   // command offered
  output logic             cmd_ready_o,   // command queue not full
  input  wire logic        cmd_write_i,   // 1 write, 0 read
  input  wire logic [7:0]  cmd_addr_i,    // serial address
  input  wire logic [15:0] cmd_data_i,    // write word, zero padded
  output logic             rd_valid_o,    // read word pulse
  output logic [15:0]      rd_data_o,     // read word
  output logic             busy_o         // frame in progress
);
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_GAP} host_state_e;

  host_state_e state_reg, state_next;
  logic [4:0]  timer_reg, timer_next;
  logic [4:0]  bit_reg, bit_next;
  logic [23:0] tx_reg, tx_next;
  logic [15:0] rx_reg, rx_next;
  logic        write_reg, write_next;
  logic        sel_n_reg, sel_n_next;
  logic        sclk_reg, sclk_next;
  logic        mosi_reg, mosi_next;
  logic        test_reg, test_next;
  logic        rd_valid_reg, rd_valid_next;
  logic [15:0] rd_data_reg, rd_data_next;
  logic        miso_s1_reg, miso_s2_reg;
  logic        q_valid, q_pop;
  logic [24:0] q_data;
  logic        half_done;

  // commands queue here; a slow link stalls the user via cmd_ready_o
  cmd_fifo #(.WIDTH(spi_port_pkg::CMD_W), .DEPTH(spi_port_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (cmd_valid_i),
    .in_ready_o  (cmd_ready_o),
    .in_data_i   ({cmd_write_i, cmd_addr_i, cmd_data_i}),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop),
    .out_data_o  (q_data)
  );

  // ----------------------------------------------------------------
  // frame engine, sclk made by dividing clk_i
  // ----------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    timer_next    = timer_reg + 5'h01;
    bit_next      = bit_reg;
    tx_next       = tx_reg;
    rx_next       = rx_reg;
    write_next    = write_reg;
    sel_n_next    = sel_n_reg;
    sclk_next     = sclk_reg;
    mosi_next     = mosi_reg;
    test_next     = test_reg;
    rd_valid_next = 1'b0;
    rd_data_next  = rd_data_reg;
    q_pop         = 1'b0;
    half_done     = (timer_reg == spi_port_pkg::HALF_LAST); // R3
    case (state_reg)
      H_IDLE: begin
        timer_next = 5'h00;
        test_next  = port_enable_i; // R7
        // a frame never opens in the cycle the enable is being dropped
        if (q_valid && test_reg && port_enable_i) begin
          q_pop      = 1'b1;
          write_next = q_data[24];
          // reads send a zero word in the data field
          tx_next    = q_data[24] ? q_data[23:0] : {q_data[23:16], 16'h0000}; // R5
          mosi_next  = tx_next[23]; // R4
          sel_n_next = 1'b0; // R6 R12
          bit_next   = 5'h00;
          state_next = H_LEAD;
        end
      end
      H_LEAD, H_LOW: begin
        if (half_done) begin
          timer_next = 5'h00;
          sclk_next  = 1'b1;
          state_next = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half_done) begin
          timer_next = 5'h00;
          // the word leads by one rise, so the last high phase carries no bit
          if (bit_reg != spi_port_pkg::BIT_LAST) begin
            rx_next = {rx_reg[14:0], miso_s2_reg}; // R11
          end
          sclk_next  = 1'b0;
          if (bit_reg == spi_port_pkg::BIT_LAST) begin
            state_next = H_TAIL;
          end else begin
            bit_next   = bit_reg + 5'h01;
            tx_next    = {tx_reg[22:0], 1'b0};
            mosi_next  = tx_reg[22]; // R4
            state_next = H_LOW;
          end
        end
      end
      H_TAIL: begin
        if (half_done) begin
          timer_next    = 5'h00;
          sel_n_next    = 1'b1; // R10
          mosi_next     = 1'b0;
          rd_valid_next = !write_reg;
          rd_data_next  = write_reg ? rd_data_reg : rx_reg;
          state_next    = H_GAP;
        end
      end
      H_GAP: begin
        if (half_done) begin
          state_next = H_IDLE;
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= H_IDLE;
      timer_reg    <= 5'h00;
      bit_reg      <= 5'h00;
      tx_reg       <= 24'h000000;
      rx_reg       <= 16'h0000;
      write_reg    <= 1'b0;
      sel_n_reg    <= 1'b1;
      sclk_reg     <= 1'b0;
      mosi_reg     <= 1'b0;
      test_reg     <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= 16'h0000;
      miso_s1_reg  <= 1'b0;
      miso_s2_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      timer_reg    <= timer_next;
      bit_reg      <= bit_next;
      tx_reg       <= tx_next;
      rx_reg       <= rx_next;
      write_reg    <= write_next;
      sel_n_reg    <= sel_n_next;
      sclk_reg     <= sclk_next;
      mosi_reg     <= mosi_next;
      test_reg     <= test_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg  <= rd_data_next;
      miso_s1_reg  <= link.miso;
      miso_s2_reg  <= miso_s1_reg;
    end
  end

  assign link.monitor_test_enable = test_reg;
  assign link.sel_n               = sel_n_reg;
  assign link.sclk                = sclk_reg;
  assign link.mosi                = mosi_reg;
  assign rd_valid_o               = rd_valid_reg;
  assign rd_data_o                = rd_data_reg;
  assign busy_o                   = !sel_n_reg;
endmodule

// >>> src/spi_port_device.sv
`timescale 1ns/1ps
//  Contract
// R1: host reads and writes memory over serial
// R2: serial writes visible on radio read port
// R3: host keeps serial clock at most 1 MHz
// R4: address and data shifted MSB first
// R5: host zero pads short data words
// R6: select active low, frames traffic
// R7: test enable input enables the port
// R8: data in on mosi, out on miso
// R9: read-only measurement count at word 20h
// R10: frame is 8-bit address, 16-bit data
// R11: capture on rising edge, output valid high
// R12: host keeps clock low at select fall
// R13: test and select low reset; monitor halts
// R14: short frames change nothing
module spi_port_device (
  input  wire logic        clk_i,          // system clock, 50 MHz
  input  wire logic        rst_i,          // sync reset, high
  spi_port_if.device       link,           // serial pins, sclk is link clock
  input  wire logic        measure_pulse_i, // one measurement done
  input  wire logic        radio_rd_i,     // radio side read request
  input  wire logic [7:0]  radio_addr_i,   // radio side word address
  output logic             radio_valid_o,  // radio read word pulse
  output logic [15:0]      radio_data_o,   // radio read word
  output logic             monitor_halt_o, // monitoring halted
  output logic [15:0]      measurement_cycle_count_o // measurement total
);
  // ----------------------------------------------------------------
  // link domain state (clocked by sclk)
  // ----------------------------------------------------------------
  logic [15:0] mem [spi_port_pkg::MEM_WORDS];
  logic        frame_clr;
  logic        port_clr;
  logic [4:0]  bit_reg, bit_next;
  logic [22:0] shift_reg, shift_next;
  logic [7:0]  addr_reg, addr_next;
  logic [15:0] out_reg, out_next;
  logic        frame_we;
  logic [15:0] frame_word;
  logic [7:0]  frame_addr;
  logic [15:0] load_word;
  logic [7:0]  wr_addr_reg, wr_addr_next;
  logic [15:0] wr_data_reg, wr_data_next;
  logic        wr_tog_reg, wr_tog_next;

  // ----------------------------------------------------------------
  // system domain state
  // ----------------------------------------------------------------
  logic [15:0] mirror [spi_port_pkg::MEM_WORDS];
  logic        test_s1_reg, test_s2_reg;
  logic        sel_s1_reg, sel_s2_reg;
  logic        tog_s1_reg, tog_s2_reg;
  logic        tog_seen_reg, tog_seen_next;
  logic        halt_reg, halt_next;
  logic [15:0] count_reg, count_next;
  logic        rvalid_reg, rvalid_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        port_rst_sys;
  logic        mirror_we;

  // frame logic clears whenever the port is off or select is high;
  // sclk may stop between frames, so nothing here waits on it
  assign frame_clr = link.sel_n | ~link.monitor_test_enable; // R6 R7
  // handover registers clear on the test and select reset combination;
  // rst_i also clears them, as no link clock may arrive before first use
  assign port_clr  = rst_i | (~link.sel_n & ~link.monitor_test_enable); // R13

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  always_comb begin
    bit_next     = bit_reg;
    shift_next   = {shift_reg[21:0], link.mosi}; // R4 R8
    addr_next    = addr_reg;
    out_next     = {out_reg[14:0], 1'b0}; // R4
    frame_addr   = {shift_reg[6:0], link.mosi};
    frame_word   = {shift_reg[14:0], link.mosi};
    frame_we     = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    wr_tog_next  = wr_tog_reg;
    // the counter word is served from the system side, not from memory
    load_word    = (frame_addr == spi_port_pkg::CYCLE_COUNT_ADDR) ?
                   count_reg : mem[frame_addr]; // R9
    if (bit_reg != spi_port_pkg::BIT_DONE) begin
      bit_next = bit_reg + 5'h01;
    end
    if (bit_reg == spi_port_pkg::ADDR_LAST) begin
      addr_next = frame_addr; // R10
      out_next  = load_word; // R1
    end
    // memory moves only on the last bit, so a cut frame leaves it alone
    if (bit_reg == spi_port_pkg::BIT_LAST) begin // R14
      frame_we     = (addr_reg != spi_port_pkg::CYCLE_COUNT_ADDR); // R9
      wr_addr_next = addr_reg;
      wr_data_next = frame_word;
      wr_tog_next  = frame_we ? ~wr_tog_reg : wr_tog_reg;
    end
  end

  // rising edge capture; miso moves on the rise, stable through high
  always_ff @(posedge link.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      bit_reg   <= 5'h00;
      shift_reg <= 23'h000000;
      addr_reg  <= 8'h00;
      out_reg   <= 16'h0000;
    end else begin
      bit_reg   <= bit_next; // R11
      shift_reg <= shift_next;
      addr_reg  <= addr_next;
      out_reg   <= out_next;
    end
  end

  // write word held steady until the next frame for the crossing
  always_ff @(posedge link.sclk or posedge port_clr) begin
    if (port_clr) begin
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 16'h0000;
      wr_tog_reg  <= 1'b0;
    end else begin
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      wr_tog_reg  <= wr_tog_next;
    end
  end

  // nonvolatile store, never cleared by any reset
  always_ff @(posedge link.sclk) begin
    if (frame_we && !frame_clr) begin
      mem[addr_reg] <= frame_word; // R1
    end
  end

  assign link.miso = out_reg[15]; // R8 R11

  // ----------------------------------------------------------------
  // system domain: synchronisers, mirror, counter, radio port
  // ----------------------------------------------------------------
  assign port_rst_sys = rst_i | (~test_s2_reg & ~sel_s2_reg); // R13

  always_comb begin
    tog_seen_next = tog_seen_reg;
    mirror_we     = 1'b0;
    halt_next     = test_s2_reg; // R13
    count_next    = count_reg;
    rvalid_next   = radio_rd_i;
    rdata_next    = rdata_reg;
    if (tog_s2_reg != tog_seen_reg) begin
      tog_seen_next = tog_s2_reg;
      mirror_we     = 1'b1; // R2
    end
    // halted monitor keeps the count still, so the link reads it safely
    if (measure_pulse_i && !test_s2_reg) begin
      count_next = count_reg + 16'h0001; // R13
    end
    if (radio_rd_i) begin
      rdata_next = (radio_addr_i == spi_port_pkg::CYCLE_COUNT_ADDR) ?
                   count_reg : mirror[radio_addr_i]; // R2 R9
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_s1_reg <= 1'b0;
      test_s2_reg <= 1'b0;
      sel_s1_reg  <= 1'b1;
      sel_s2_reg  <= 1'b1;
      tog_s1_reg  <= 1'b0;
      tog_s2_reg  <= 1'b0;
      halt_reg    <= 1'b0;
      count_reg   <= spi_port_pkg::CYCLE_COUNT_RESET;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 16'h0000;
    end else begin
      test_s1_reg <= link.monitor_test_enable;
      test_s2_reg <= test_s1_reg;
      sel_s1_reg  <= link.sel_n;
      sel_s2_reg  <= sel_s1_reg;
      tog_s1_reg  <= wr_tog_reg;
      tog_s2_reg  <= tog_s1_reg;
      halt_reg    <= halt_next;
      count_reg   <= count_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
    end
  end

  // seen toggle follows the port reset so a cleared link toggle is no event
  always_ff @(posedge clk_i) begin
    if (port_rst_sys) begin
      tog_seen_reg <= 1'b0;
    end else begin
      tog_seen_reg <= tog_seen_next;
    end
  end

  // word and address are stable long before the synced toggle arrives
  always_ff @(posedge clk_i) begin
    if (mirror_we) begin
      mirror[wr_addr_reg] <= wr_data_reg; // R2
    end
  end

  assign radio_valid_o             = rvalid_reg;
  assign radio_data_o              = rdata_reg;
  assign monitor_halt_o            = halt_reg;
  assign measurement_cycle_count_o = count_reg;
endmodule

// >>> verification/spi_port_asserts.sv
`timescale 1ns/1ps
module spi_port_asserts (
  input  wire logic clk_i,               // system clock
  input  wire logic rst_i,               // sync reset, high
  input  wire logic monitor_test_enable, // port enable
  input  wire logic sel_n,               // frame select, low active
  input  wire logic sclk,                // link clock
  input  wire logic mosi,                // host data
  input  wire logic miso                 // device data
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  localparam int HALF_MIN = spi_port_pkg::HALF_CYCLES - 1;
  logic [7:0] half_reg, half_next;
  logic [4:0] rise_reg, rise_next;
  logic       sclk_reg, sclk_next;

  // saturate so a long idle cannot wrap into a short phase
  always_comb begin
    sclk_next = sclk;
    half_next = (half_reg == 8'hff) ? half_reg : half_reg + 8'h01;
    if (sclk != sclk_reg) half_next = 8'h00;
    rise_next = rise_reg;
    if (sel_n) rise_next = 5'h00;
    else if (sclk && !sclk_reg) rise_next = rise_reg + 5'h01;
  end

  // register the helper state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_reg <= 8'hff;
      rise_reg <= 5'h00;
      sclk_reg <= 1'b0;
    end else begin
      half_reg <= half_next;
      rise_reg <= rise_next;
      sclk_reg <= sclk_next;
    end
  end

  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_select_needs_enable: assert property (!sel_n |-> monitor_test_enable)
    else $error("select low while port disabled");
  a_enable_idle_only: assert property ($changed(monitor_test_enable) |-> sel_n && $past(sel_n))
    else $error("test enable changed inside a frame");
  a_clock_low_select: assert property ($fell(sel_n) |-> !sclk)
    else $error("clock high when select fell");
  a_clock_idle_low: assert property (sel_n |-> !sclk)
    else $error("clock high outside a frame");
  a_half_period_min: assert property ((sclk != sclk_reg) && !sel_n |-> half_reg >= HALF_MIN)
    else $error("link clock phase too short");
  a_frame_bit_count: assert property ($rose(sel_n) |-> rise_reg == spi_port_pkg::BIT_DONE)
    else $error("frame did not carry 24 clock rises");
  a_mosi_steady_high: assert property (!sel_n && sclk |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_miso_steady_high: assert property (!sel_n && sclk && $past(sclk) |-> miso === $past(miso))
    else $error("device data moved while clock high");
  a_miso_quiet_idle: assert property (sel_n && $past(sel_n) |-> !miso)
    else $error("device data not cleared outside frame");
endmodule

// >>> verification/monitor_eeprom_serial_port_test.sv
`timescale 1ns/1ps
module monitor_eeprom_serial_port_test;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [15:0] d;
    logic [15:0] x;
  } row_s;
  logic        clk_i, rst_i, port_enable_i, cmd_valid_i, cmd_ready_o, cmd_write_i;
  logic        rd_valid_o, busy_o, measure_pulse_i, radio_rd_i, radio_valid_o;
  logic        monitor_halt_o, radio_valid_b, v, vb, rd_seen;
  logic [7:0]  cmd_addr_i, radio_addr_i;
  logic [15:0] cmd_data_i, rd_data_o, radio_data_o, radio_data_b, count_o, dv, db, rd_got;
  logic [23:0] fr_bits;
  int          fail_count = 0, check_count = 0, frames = 0, fr_cnt = 0;
  // plain cases: write, readback, queued word, read-only count
  row_s rows [8] = '{'{1'h1, 8'h3a, 16'h0080, 16'h0000}, '{1'h0, 8'h3a, 16'h0000, 16'h0080},
                     '{1'h1, 8'h01, 16'h00c8, 16'h0000}, '{1'h0, 8'h01, 16'h0000, 16'h00c8},
                     '{1'h0, 8'h40, 16'h0000, 16'h1000}, '{1'h0, 8'h47, 16'h0000, 16'h1007},
                     '{1'h1, 8'h20, 16'h1234, 16'h0000}, '{1'h0, 8'h20, 16'h0000, 16'h0003}};

  // ----------------------------------------------------------------
  // ends under test
  // ----------------------------------------------------------------
  spi_port_if lk ();
  spi_port_if lk2 ();
  spi_port_host i_spi_port_host (.clk_i(clk_i), .rst_i(rst_i), .link(lk),
    .port_enable_i(port_enable_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .busy_o(busy_o));
  spi_port_device i_spi_port_device (.clk_i(clk_i), .rst_i(rst_i), .link(lk),
    .measure_pulse_i(measure_pulse_i), .radio_rd_i(radio_rd_i), .radio_addr_i(radio_addr_i),
    .radio_valid_o(radio_valid_o), .radio_data_o(radio_data_o),
    .monitor_halt_o(monitor_halt_o), .measurement_cycle_count_o(count_o));
  // second device fed by a bench driver that cuts frames short
  spi_port_device i_spi_port_device_b (.clk_i(clk_i), .rst_i(rst_i), .link(lk2),
    .measure_pulse_i(measure_pulse_i), .radio_rd_i(radio_rd_i), .radio_addr_i(radio_addr_i),
    .radio_valid_o(radio_valid_b), .radio_data_o(radio_data_b),
    .monitor_halt_o(), .measurement_cycle_count_o());
  spi_port_asserts i_spi_port_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .monitor_test_enable(lk.monitor_test_enable), .sel_n(lk.sel_n), .sclk(lk.sclk),
    .mosi(lk.mosi), .miso(lk.miso));

  // ----------------------------------------------------------------
  // monitors and tasks
  // ----------------------------------------------------------------
  // wire watch: collect bits at each rise, count frames
  always @(posedge lk.sclk) if (lk.sel_n === 1'b0) begin
    fr_bits = {fr_bits[22:0], lk.mosi};
    fr_cnt++;
  end
  always @(negedge lk.sel_n) begin
    fr_cnt = 0;
    check("clock at select", 24'h0, 24'(lk.sclk));
  end
  always @(posedge lk.sel_n) if (rst_i === 1'b0) frames++;
  // read word is a one-cycle pulse, so catch it here
  always @(posedge clk_i) if (rd_valid_o === 1'b1) begin
    rd_seen = 1'b1;
    rd_got = rd_data_o;
  end

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // leaves valid high so back-to-back pushes never toggle it
  task automatic push(input row_s r);
    rd_seen = 1'b0;
    cmd_valid_i = 1'b1;
    cmd_write_i = r.wr;
    cmd_addr_i = r.a;
    cmd_data_i = r.d;
    while (cmd_ready_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
  endtask

  // tail covers the 25-cycle gap between frames
  task automatic wait_idle(input int target);
    int n;
    n = 0;
    while (n < 20000 && (frames < target || busy_o !== 1'b0)) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 20000) check("idle wait limit", 24'h0, 24'h1);
    repeat (30) @(negedge clk_i);
  endtask

  task automatic radio(input logic [7:0] a);
    radio_addr_i = a;
    radio_rd_i = 1'b1;
    @(negedge clk_i);
    radio_rd_i = 1'b0;
    v = radio_valid_o;
    dv = radio_data_o;
    vb = radio_valid_b;
    db = radio_data_b;
  endtask

  // bench-made link clock, 80 ns, only inside the frame
  task automatic bang(input logic [23:0] f, input int n);
    lk2.monitor_test_enable = 1'b1;
    #100 lk2.sel_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      lk2.mosi = f[i];
      #40 lk2.sclk = 1'b1;
      #40 lk2.sclk = 1'b0;
    end
    #40 lk2.sel_n = 1'b1;
    lk2.mosi = 1'b0;
    #100 lk2.monitor_test_enable = 1'b0;
    repeat (10) @(negedge clk_i);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    rst_i = 1'b1;
    port_enable_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_write_i = 1'b0;
    cmd_addr_i = 8'h00;
    cmd_data_i = 16'h0000;
    measure_pulse_i = 1'b0;
    radio_rd_i = 1'b0;
    radio_addr_i = 8'h00;
    lk2.monitor_test_enable = 1'b0;
    lk2.sel_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.mosi = 1'b0;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    // count measurements, then queue eight writes with the port off
    repeat (3) begin
      @(negedge clk_i) measure_pulse_i = 1'b1;
      @(negedge clk_i) measure_pulse_i = 1'b0;
      repeat (3) @(negedge clk_i);
    end
    for (int i = 0; i < 8; i++) push('{1'h1, 8'h40 + 8'(i), 16'h1000 + 16'(i), 16'h0000});
    cmd_valid_i = 1'b0;
    repeat (200) @(negedge clk_i);
    check("queue full refuses", 24'h0, 24'(cmd_ready_o));
    check("frames while disabled", 24'h0, 24'(frames));
    check("halt while disabled", 24'h0, 24'(monitor_halt_o));
    check("cycle count", 24'h3, 24'(count_o));
    $display("test fill done");
    // enable: the queue drains, monitoring halts and stops counting
    port_enable_i = 1'b1;
    wait_idle(8);
    check("frames drained", 24'h8, 24'(frames));
    check("halt while enabled", 24'h1, 24'(monitor_halt_o));
    @(negedge clk_i) measure_pulse_i = 1'b1;
    @(negedge clk_i) measure_pulse_i = 1'b0;
    repeat (8) @(negedge clk_i);
    check("count frozen", 24'h3, 24'(count_o));
    radio(8'h47);
    check("radio valid", 24'h1, 24'(v));
    check("radio word", 24'h1007, 24'(dv));
    $display("test drain done");
    for (int i = 0; i < 8; i++) begin
      int t;
      t = frames + 1;
      push(rows[i]);
      cmd_valid_i = 1'b0;
      wait_idle(t);
      check("frame bits", 24'h18, 24'(fr_cnt));
      check("frame", {rows[i].a, rows[i].wr ? rows[i].d : 16'h0000}, fr_bits);
      check("read seen", 24'(!rows[i].wr), 24'(rd_seen));
      if (!rows[i].wr) check("read word", 24'(rows[i].x), 24'(rd_got));
      $display("test row %0d done", i);
    end
    // full frame lands, a frame cut short must not
    bang({8'h33, 16'ha5a5}, 24);
    radio(8'h33);
    check("full frame word", 24'ha5a5, 24'(db));
    bang({8'h33, 16'h5a5a}, 20);
    radio(8'h33);
    check("radio valid b", 24'h1, 24'(vb));
    check("short frame word", 24'ha5a5, 24'(db));
    $display("test short frame done");
    print_verdict();
  end
endmodule
